// ==== core/flash_reader_pkg.sv ====
// Shared constants and types for the serial flash boot reader
// Assumes a 250 MHz system clock and a single flash bus owner at a time
package flash_reader_pkg;
    // Clock rates in MHz
    localparam int SYS_CLK_MHZ = 250;
    localparam int SCK_MAX_MHZ = 25;
    // Divider: shortest legal serial clock period in system cycles, rounded up
    localparam int DIV_W = 8;
    localparam logic [7:0] DIV_MIN = 8'((SYS_CLK_MHZ + SCK_MAX_MHZ - 1) / SCK_MAX_MHZ);
    // Configuration reset values, 31 cycles gives about 8.1 MHz
    localparam logic [7:0] CLK_DIV_RST = 8'h1f;
    localparam int GAP_W = 4;
    localparam logic [3:0] GAP_RST = 4'hf;
    localparam logic FAST_RST = 1'b0;
    localparam logic WIDE_RST = 1'b0;
    // Flash commands
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_FAST = 8'h0b;
    // Addressing
    localparam int ADDR_W = 28;
    localparam int SEL_LSB = 24;
    localparam logic [27:0] WORD_STEP = 28'h0000004;
    // Bit counts of the transaction phases
    localparam logic [5:0] HDR_NARROW = 6'h20;
    localparam logic [5:0] HDR_WIDE = 6'h28;
    localparam logic [5:0] DUMMY_BITS = 6'h08;
    localparam logic [5:0] WORD_BITS = 6'h20;
    // Access sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    // Response buffer
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_GAP = 3'b001,
        ST_LOW = 3'b010,
        ST_HIGH = 3'b011,
        ST_PUSH = 3'b100,
        ST_WAIT = 3'b101
    } eng_state_type;
endpackage : flash_reader_pkg

// ==== core/stream_fifo.sv ====
// Small synchronous FIFO with registered full and empty flags
// Assumes one clock, active-low asynchronous reset, DEPTH a power of two
module stream_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data_o = mem_r[rp_r];

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_i) begin
            if (push && wp_r == AW'(i)) begin
                mem_r[i] <= in_data_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            wp_r <= push ? wp_r + 1'b1 : wp_r;
            rp_r <= pop ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_nxt;
            in_ready_o <= cnt_nxt != (AW+1)'(DEPTH);
            out_valid_o <= cnt_nxt != '0;
        end
    end
endmodule : stream_fifo

// ==== core/serial_flash_boot_reader.sv ====
// Memory-mapped serial flash reader: bus reads become flash read transactions
// Assumes synchronous inputs, one 250 MHz clock and a flash in clock mode 0

module serial_flash_boot_reader
    import flash_reader_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic req_valid_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [1:0] req_size_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [DATA_W-1:0] rsp_data_o,
    input wire logic rsp_ready_i,
    input wire logic cfg_load_i,
    input wire logic [DIV_W-1:0] clk_divider_i,
    input wire logic [GAP_W-1:0] select_idle_gap_i,
    input wire logic fast_read_select_i,
    input wire logic wide_address_enable_i,
    input wire logic owner_is_boot_i,
    input wire logic pin_override_enable_i,
    input wire logic ovr_sck_i,
    input wire logic ovr_sck_oen_i,
    input wire logic ovr_sdo_i,
    input wire logic ovr_sdo_oen_i,
    input wire logic [3:0] ovr_sel_n_i,
    input wire logic [3:0] ovr_sel_oen_i,
    input wire logic serial_data_in_i,
    output logic serial_clk_o,
    output logic serial_clk_oen_o,
    output logic serial_data_out_o,
    output logic serial_data_out_oen_o,
    output logic flash_select_zero_n_o,
    output logic flash_select_zero_oen_o,
    output logic [2:0] flash_select_upper_n_o,
    output logic [2:0] flash_select_upper_oen_o,
    output logic sampled_input_level_o
);
    eng_state_type state_r, state_nxt;
    logic [DIV_W-1:0] div_r, act_div_r, new_div, hi_len, lo_len, ph_cnt_r, ph_nxt;
    logic [GAP_W-1:0] gap_r, gap_left_r;
    logic fast_r, wide_r, act_fast_r, act_wide_r;
    logic [1:0] sel_r, req_off_r, req_size_r, fmt_off, fmt_size;
    logic [ADDR_W-1:0] cur_addr_r, req_word;
    logic [5:0] hdr_left_r, dat_left_r, hdr_load;
    logic [47:0] tx_sr_r, tx_load;
    logic [7:0] cmd;
    logic [31:0] rx_sr_r, rx_word, le_word, pf_data_r, push_data_r, fmt_src, fmt_out;
    logic demand_r, req_rdy_r, run, accept, hit, start, cs_act, ph_end;
    logic bit_end, word_end, frame_go, fifo_rdy, push_req;
    logic sck_nxt, sdo_nxt, sck_oen_nxt, sdo_oen_nxt;
    logic [3:0] eng_sel_n, sel_n_nxt, sel_oen_nxt;
    logic sck_pin_r, sdo_pin_r, sck_oen_r, sdo_oen_r;
    logic [3:0] sel_pin_n_r, sel_oen_r;

    // Request decode
    assign run = owner_is_boot_i && !pin_override_enable_i;
    assign accept = req_valid_i && req_rdy_r;
    assign req_word = {req_addr_i[ADDR_W-1:2], 2'h0};
    assign hit = run && state_r == ST_WAIT && req_word == cur_addr_r
        && (act_wide_r || req_addr_i[SEL_LSB+:2] == sel_r);
    assign start = accept && (state_r == ST_IDLE || !hit);
    assign new_div = (div_r < DIV_MIN) ? DIV_MIN : div_r;
    assign hi_len = {1'b0, act_div_r[DIV_W-1:1]};
    assign lo_len = act_div_r - hi_len;
    assign ph_end = ph_cnt_r == 8'h00;
    assign bit_end = run && state_r == ST_HIGH && ph_end;
    assign word_end = bit_end && hdr_left_r == 6'h00 && dat_left_r == 6'h01;
    assign frame_go = run && state_r == ST_GAP && ph_end && gap_left_r == 4'h0;
    assign cs_act = state_r inside {ST_LOW, ST_HIGH, ST_PUSH, ST_WAIT};
    // No push while the engine is frozen by override or ownership
    assign push_req = run && state_r == ST_PUSH;

    // Command and header layout
    assign cmd = act_fast_r ? CMD_FAST : CMD_READ;
    assign tx_load = act_wide_r ? {cmd, 4'h0, cur_addr_r, 8'h00}
                                : {cmd, cur_addr_r[23:0], 16'h0000};
    assign hdr_load = (act_wide_r ? HDR_WIDE : HDR_NARROW)
        + (act_fast_r ? DUMMY_BITS : 6'h00);

    // Received bytes arrive lowest address first
    assign rx_word = {rx_sr_r[30:0], serial_data_in_i};
    assign le_word = {rx_word[7:0], rx_word[15:8], rx_word[23:16], rx_word[31:24]};
    assign fmt_src = hit ? pf_data_r : le_word;
    assign fmt_off = hit ? req_addr_i[1:0] : req_off_r;
    assign fmt_size = hit ? req_size_i : req_size_r;
    assign fmt_out = (fmt_src >> {fmt_off, 3'h0})
        & (fmt_size == SIZE_BYTE ? 32'h000000ff :
           fmt_size == SIZE_HALF ? 32'h0000ffff : 32'hffffffff);

    // Pin selection between engine and software
    assign eng_sel_n = cs_act ? ~(4'h1 << sel_r) : 4'hf;
    assign sck_nxt = pin_override_enable_i ? ovr_sck_i : state_r == ST_HIGH;
    assign sdo_nxt = pin_override_enable_i ? ovr_sdo_i : tx_sr_r[47];
    assign sel_n_nxt = pin_override_enable_i ? ovr_sel_n_i : eng_sel_n;
    assign sck_oen_nxt = !owner_is_boot_i || (pin_override_enable_i && ovr_sck_oen_i);
    assign sdo_oen_nxt = !owner_is_boot_i || (pin_override_enable_i && ovr_sdo_oen_i);
    assign sel_oen_nxt = !owner_is_boot_i ? 4'hf
        : pin_override_enable_i ? ovr_sel_oen_i : 4'h0;

    // Engine sequencing
    always_comb begin
        state_nxt = state_r;
        if (!run) begin
            if (state_r == ST_IDLE && accept) begin
                state_nxt = ST_GAP;
            end else if (state_r == ST_WAIT) begin
                state_nxt = accept ? ST_GAP : ST_IDLE;
            end
        end else begin
            unique case (state_r)
                ST_IDLE: if (accept) state_nxt = ST_GAP;
                ST_GAP: if (frame_go) state_nxt = ST_LOW;
                ST_LOW: if (ph_end) state_nxt = ST_HIGH;
                ST_HIGH: begin
                    if (ph_end) begin
                        state_nxt = !word_end ? ST_LOW : demand_r ? ST_PUSH : ST_WAIT;
                    end
                end
                ST_PUSH: if (fifo_rdy) state_nxt = ST_LOW;
                ST_WAIT: if (accept) state_nxt = hit ? ST_PUSH : ST_GAP;
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    // Phase counter: gap periods, then low and high halves of each clock
    always_comb begin
        ph_nxt = ph_cnt_r;
        if (start) begin
            ph_nxt = new_div - 8'h01;
        end else if (run && state_r == ST_GAP) begin
            ph_nxt = !ph_end ? ph_cnt_r - 8'h01
                   : (gap_left_r == 4'h0) ? lo_len - 8'h01 : act_div_r - 8'h01;
        end else if (run && state_r == ST_LOW) begin
            ph_nxt = ph_end ? hi_len - 8'h01 : ph_cnt_r - 8'h01;
        end else if (run && state_r == ST_HIGH) begin
            ph_nxt = ph_end ? lo_len - 8'h01 : ph_cnt_r - 8'h01;
        end else if (state_r == ST_PUSH || state_r == ST_WAIT) begin
            ph_nxt = lo_len - 8'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= ST_IDLE;
            ph_cnt_r <= 8'h00;
            req_rdy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ph_cnt_r <= ph_nxt;
            req_rdy_r <= state_nxt == ST_IDLE || state_nxt == ST_WAIT;
        end
    end

    // Configuration held from reset values until software loads new ones
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_r <= CLK_DIV_RST;
            gap_r <= GAP_RST;
            fast_r <= FAST_RST;
            wide_r <= WIDE_RST;
        end else if (cfg_load_i) begin
            div_r <= clk_divider_i;
            gap_r <= select_idle_gap_i;
            fast_r <= fast_read_select_i;
            wide_r <= wide_address_enable_i;
        end
    end

    // Active copy changes only while the select is released
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            act_div_r <= CLK_DIV_RST;
            act_fast_r <= FAST_RST;
            act_wide_r <= WIDE_RST;
        end else if (start) begin
            act_div_r <= new_div;
            act_fast_r <= fast_r;
            act_wide_r <= wide_r;
        end
    end

    // Request capture and word address tracking
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cur_addr_r <= '0;
            sel_r <= 2'h0;
            req_off_r <= 2'h0;
            req_size_r <= 2'h0;
            demand_r <= 1'b0;
            gap_left_r <= 4'h0;
        end else begin
            if (start) begin
                cur_addr_r <= req_word;
                sel_r <= wide_r ? 2'h0 : req_addr_i[SEL_LSB+:2];
                gap_left_r <= gap_r;
                demand_r <= 1'b1;
            end else if (push_req && fifo_rdy) begin
                cur_addr_r <= cur_addr_r + WORD_STEP;
                demand_r <= 1'b0;
            end else if (run && state_r == ST_GAP && ph_end && gap_left_r != 4'h0) begin
                gap_left_r <= gap_left_r - 4'h1;
            end
            if (accept) begin
                req_off_r <= req_addr_i[1:0];
                req_size_r <= req_size_i;
            end
        end
    end

    // Shifters: out on the falling edge, in just before it
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_sr_r <= '0;
            rx_sr_r <= '0;
            hdr_left_r <= 6'h00;
            dat_left_r <= 6'h00;
        end else if (frame_go) begin
            tx_sr_r <= tx_load;
            hdr_left_r <= hdr_load;
            dat_left_r <= WORD_BITS;
        end else if (bit_end && hdr_left_r != 6'h00) begin
            tx_sr_r <= {tx_sr_r[46:0], 1'b0};
            hdr_left_r <= hdr_left_r - 6'h01;
        end else if (bit_end) begin
            rx_sr_r <= rx_word;
            dat_left_r <= word_end ? WORD_BITS : dat_left_r - 6'h01;
        end
    end

    // Prefetched word and the word handed to the buffer
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pf_data_r <= 32'h00000000;
            push_data_r <= 32'h00000000;
        end else begin
            if (word_end) begin
                pf_data_r <= le_word;
            end
            if ((word_end && demand_r) || (accept && hit)) begin
                push_data_r <= fmt_out;
            end
        end
    end

    // Registered pins
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_pin_r <= 1'b0;
            sdo_pin_r <= 1'b0;
            sel_pin_n_r <= 4'hf;
            sck_oen_r <= 1'b1;
            sdo_oen_r <= 1'b1;
            sel_oen_r <= 4'hf;
            sampled_input_level_o <= 1'b0;
        end else begin
            sck_pin_r <= sck_nxt;
            sdo_pin_r <= sdo_nxt;
            sel_pin_n_r <= sel_n_nxt;
            sck_oen_r <= sck_oen_nxt;
            sdo_oen_r <= sdo_oen_nxt;
            sel_oen_r <= sel_oen_nxt;
            sampled_input_level_o <= serial_data_in_i;
        end
    end

    assign req_ready_o = req_rdy_r;
    assign serial_clk_o = sck_pin_r;
    assign serial_data_out_o = sdo_pin_r;
    assign serial_clk_oen_o = sck_oen_r;
    assign serial_data_out_oen_o = sdo_oen_r;
    assign flash_select_zero_n_o = sel_pin_n_r[0];
    assign flash_select_upper_n_o = sel_pin_n_r[3:1];
    assign flash_select_zero_oen_o = sel_oen_r[0];
    assign flash_select_upper_oen_o = sel_oen_r[3:1];

    stream_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rsp_fifo (
        .clk_i(mclk_i),
        .rstn_i(rstn_i),
        .in_valid_i(push_req),
        .in_ready_o(fifo_rdy),
        .in_data_i(push_data_r),
        .out_valid_o(rsp_valid_o),
        .out_ready_i(rsp_ready_i),
        .out_data_o(rsp_data_o)
    );

    // Checks
    property p_one_sel;
        @(posedge mclk_i) disable iff (!rstn_i)
        !$past(pin_override_enable_i) |-> $countones(~sel_pin_n_r) <= 1;
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects active");

    property p_wide_sel;
        @(posedge mclk_i) disable iff (!rstn_i)
        act_wide_r && cs_act |-> sel_r == 2'h0;
    endproperty
    a_wide_sel: assert property (p_wide_sel) else $error("wide mode off select 0");

    property p_ovr_pins;
        @(posedge mclk_i) disable iff (!rstn_i)
        pin_override_enable_i && owner_is_boot_i |=> serial_clk_o == $past(ovr_sck_i)
            && serial_data_out_oen_o == $past(ovr_sdo_oen_i);
    endproperty
    a_ovr_pins: assert property (p_ovr_pins) else $error("override pins wrong");

    property p_sel_pick;
        @(posedge mclk_i) disable iff (!rstn_i)
        start && !wide_r |=> sel_r == $past(req_addr_i[SEL_LSB+:2]);
    endproperty
    a_sel_pick: assert property (p_sel_pick) else $error("wrong select");

    property p_header;
        @(posedge mclk_i) disable iff (!rstn_i)
        frame_go |=> tx_sr_r[47:40] == (act_fast_r ? CMD_FAST : CMD_READ)
            && hdr_left_r == (act_wide_r ? 6'h28 : 6'h20) + (act_fast_r ? 6'h08 : 6'h00);
    endproperty
    a_header: assert property (p_header) else $error("bad header");

    property p_gap;
        @(posedge mclk_i) disable iff (!rstn_i)
        $fell(cs_act) && run && state_r == ST_GAP |-> !cs_act [*8];
    endproperty
    a_gap: assert property (p_gap) else $error("select gap too short");

    property p_sample;
        @(posedge mclk_i) disable iff (!rstn_i)
        bit_end && hdr_left_r == 6'h00 && !pin_override_enable_i
            |=> rx_sr_r[0] == $past(serial_data_in_i) && serial_clk_o;
    endproperty
    a_sample: assert property (p_sample) else $error("sample not before fall");

    property p_prefetch;
        @(posedge mclk_i) disable iff (!rstn_i)
        state_r == ST_PUSH && fifo_rdy && run |=> state_r == ST_LOW && dat_left_r == 6'h20;
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("no prefetch");

    property p_byte;
        @(posedge mclk_i) disable iff (!rstn_i)
        state_r == ST_PUSH && req_size_r == SIZE_BYTE |-> push_data_r[31:8] == 24'h000000;
    endproperty
    a_byte: assert property (p_byte) else $error("byte read not masked");

    property p_cfg_hold;
        @(posedge mclk_i) disable iff (!rstn_i)
        cs_act && $past(cs_act) |-> $stable(act_div_r) && $stable(act_wide_r);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed mid access");
endmodule : serial_flash_boot_reader

// ==== verification/flash_model.sv ====
// Behavioural serial flash answering read commands in clock mode 0
// Assumes pin enables already resolved to wire levels
module flash_model (
    input wire logic sck_i,
    input wire logic [3:0] sel_n_i,
    input wire logic mosi_i,
    input wire logic wide_i,
    input wire logic fast_i,
    output logic miso_o,
    output logic [7:0] cmd_o,
    output logic [31:0] addr_o,
    output logic [1:0] sel_o,
    output int n_bad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    int na;
    int hd;
    int k;
    logic [7:0] b;
    function automatic logic [7:0] fb(input logic [1:0] s, input logic [27:0] a);
        return a[7:0] ^ a[15:8] ^ {a[27:24], a[19:18], s};
    endfunction : fb
    initial miso_o = 1'b0;
    always @(sel_n_i) begin
        #0.1;
        if ($countones(~sel_n_i) > 1) n_bad_o++;
    end
    always @(negedge (&sel_n_i)) begin
        cnt = 0;
        addr_o = 32'h0;
        na = wide_i ? 40 : 32;
        hd = na + (fast_i ? 8 : 0);
        sel_o = sel_n_i[0] ? (sel_n_i[1] ? (sel_n_i[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
    end
    // Released data line shows the inverse of its last level
    always @(posedge (&sel_n_i)) miso_o = ~miso_o;
    always @(posedge sck_i) begin
        if (!(&sel_n_i)) begin
            if (cnt < 8) cmd_o = {cmd_o[6:0], mosi_i};
            else if (cnt < na) addr_o = {addr_o[30:0], mosi_i};
            cnt++;
        end
    end
    // Data changes on the falling edge, steady when sampled
    always @(negedge sck_i) begin
        if (!(&sel_n_i)) begin
            k = cnt - hd;
            b = fb(sel_o, addr_o[27:0] + 28'(k / 8));
            miso_o = (k < 0) ? ~miso_o : b[7 - k % 8];
        end
    end
endmodule : flash_model

// ==== verification/serial_flash_boot_reader_bench.sv ====
// Self-checking bench for the serial flash boot reader
// Assumes flash_model on the pins, pull-ups on the selects
module serial_flash_boot_reader_bench
    import flash_reader_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 60000;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic req_valid = 1'b0;
    logic [27:0] req_addr = 28'h0;
    logic [1:0] req_size = 2'h2;
    logic rsp_ready = 1'b1;
    logic cfg_load = 1'b0;
    logic [7:0] div = 8'h0a;
    logic [3:0] gap = 4'h0;
    logic fast = 1'b0;
    logic wide = 1'b0;
    logic owner = 1'b1;
    logic ovr = 1'b0;
    logic [11:0] ob = 12'hfff;
    logic sdi_tb = 1'b0;
    logic req_ready, rsp_valid, sck, sck_oen, sdo, sdo_oen, s0_n, s0oen, smp, miso;
    logic [31:0] rsp_data, m_addr;
    logic [2:0] su_n, suoen;
    logic [7:0] m_cmd;
    logic [1:0] m_sel, last_s;
    logic [27:0] last_fa, a;
    logic [31:0] expq[$];
    int n_fail, num_checks, cyc, m_bad, take_cyc, pop_cyc, per, rise, gcnt, last_gap;
    wire sck_w = sck & ~sck_oen;
    wire mosi_w = sdo | sdo_oen;
    wire [3:0] sel_n_w = {su_n | suoen, s0_n | s0oen};
    wire sdi = ovr ? sdi_tb : miso;
    serial_flash_boot_reader dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_valid_i(req_valid),
        .req_addr_i(req_addr), .req_size_i(req_size), .req_ready_o(req_ready),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_ready_i(rsp_ready),
        .cfg_load_i(cfg_load), .clk_divider_i(div), .select_idle_gap_i(gap),
        .fast_read_select_i(fast), .wide_address_enable_i(wide), .owner_is_boot_i(owner),
        .pin_override_enable_i(ovr), .ovr_sck_i(ob[11]), .ovr_sck_oen_i(ob[10]),
        .ovr_sdo_i(ob[9]), .ovr_sdo_oen_i(ob[8]), .ovr_sel_n_i(ob[7:4]),
        .ovr_sel_oen_i(ob[3:0]), .serial_data_in_i(sdi), .serial_clk_o(sck),
        .serial_clk_oen_o(sck_oen), .serial_data_out_o(sdo), .serial_data_out_oen_o(sdo_oen),
        .flash_select_zero_n_o(s0_n), .flash_select_zero_oen_o(s0oen),
        .flash_select_upper_n_o(su_n), .flash_select_upper_oen_o(suoen),
        .sampled_input_level_o(smp));
    flash_model flash_u (.sck_i(sck_w), .sel_n_i(sel_n_w), .mosi_i(mosi_w), .wide_i(wide),
        .fast_i(fast), .miso_o(miso), .cmd_o(m_cmd), .addr_o(m_addr), .sel_o(m_sel),
        .n_bad_o(m_bad));
    task automatic close_out();
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    function automatic logic [7:0] fb(input logic [1:0] s, input logic [27:0] x);
        return x[7:0] ^ x[15:8] ^ {x[27:24], x[19:18], s};
    endfunction : fb
    task automatic rd(input logic [27:0] x, input logic [1:0] sz);
        logic [31:0] w;
        @(negedge mclk_i);
        last_s = wide ? 2'h0 : x[25:24];
        last_fa = wide ? x : {4'h0, x[23:0]};
        for (int i = 0; i < 4; i++) w[8*i+:8] = fb(last_s, {last_fa[27:2], 2'h0} + 28'(i));
        w = w >> (8 * x[1:0]);
        if (sz == SIZE_BYTE) w = w & 32'h000000ff;
        if (sz == SIZE_HALF) w = w & 32'h0000ffff;
        expq.push_back(w);
        {req_addr, req_size, req_valid} = {x, sz, 1'b1};
        for (int i = 0; i < 9000 && req_ready !== 1'b1; i++) @(negedge mclk_i);
        chk(req_ready === 1'b1, "request not taken");
        @(posedge mclk_i);
        @(negedge mclk_i);
        take_cyc = cyc;
        req_valid = 1'b0;
    endtask : rd
    task automatic wait_rsp();
        for (int i = 0; i < 9000 && expq.size() > 0; i++) @(negedge mclk_i);
        chk(expq.size() == 0, "response missing");
    endtask : wait_rsp
    task automatic cfg(input logic [7:0] d, input logic [3:0] g, input logic f, w);
        @(negedge mclk_i);
        {div, gap, fast, wide, cfg_load} = {d, g, f, w, 1'b1};
        @(negedge mclk_i);
        cfg_load = 1'b0;
    endtask : cfg
    task automatic miss(input logic [27:0] x, input logic [7:0] c);
        rd(x, 2'h2);
        wait_rsp();
        chk(m_cmd === c, "command");
        chk(m_sel === last_s, "select");
        chk(m_addr[27:2] === last_fa[27:2], "address");
    endtask : miss
    initial forever #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc++;
        if ($rose(sck_w)) begin
            per = cyc - rise;
            rise = cyc;
        end
        if (&sel_n_w) gcnt++;
        else if (gcnt > 0) begin
            last_gap = gcnt;
            gcnt = 0;
        end
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            pop_cyc = cyc;
            if (expq.size() == 0) chk(1'b0, "unexpected data");
            else chk(rsp_data === expq.pop_front(), "read data");
        end
        if (cyc == LIMIT) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        void'($urandom(16187));
        repeat (2) @(negedge mclk_i);
        chk({s0_n, su_n, s0oen, suoen, req_ready} === 9'h1fe, "reset pins");
        rstn_i = 1'b1;
        for (int s = 0; s < 4; s++) begin
            miss({2'h0, 2'(s), 24'($urandom) & 24'hfffffc}, CMD_READ);
        end
        chk(last_gap === 16 * 31, "default gap");
        chk(per === 31, "default clock");
        a = {2'h0, last_s, last_fa[23:0] + 24'h4};
        rd(a, 2'h2);
        wait_rsp();
        chk(pop_cyc - take_cyc <= 4, "prefetch hit");
        rd(a + 28'h5, SIZE_BYTE);
        rd(a + 28'h6, SIZE_HALF);
        rd(a + 28'h9, 2'h2);
        rd(a + 28'h40, 2'h2);
        repeat (4) @(negedge mclk_i);
        for (int i = 0; i < 900 && (&sel_n_w); i++) @(negedge mclk_i);
        cfg(8'h04, 4'h2, 1'b1, 1'b0);
        wait_rsp();
        repeat (2) miss(28'($urandom) & 28'hffffffc, CMD_FAST);
        chk(per === 10, "clamped clock");
        chk(last_gap >= 30 && last_gap <= 40, "idle gap");
        cfg(8'h0c, 4'h1, 1'b0, 1'b1);
        repeat (2) miss({4'h9, 24'($urandom) & 24'hfffffc}, CMD_READ);
        rsp_ready = 1'b0;
        a = last_fa + 28'h10;
        for (int i = 0; i < 5; i++) rd(a + 28'(4 * i), 2'h2);
        repeat (40) @(negedge mclk_i);
        chk(req_ready === 1'b0 && rsp_valid === 1'b1, "full buffer");
        rsp_ready = 1'b1;
        wait_rsp();
        ovr = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ob = {4'($urandom), ~(4'h1 << i), 4'($urandom)};
            sdi_tb = 1'($urandom);
            repeat (3) @(negedge mclk_i);
            chk({sck, sck_oen, sdo, sdo_oen} === ob[11:8], "override pins");
            chk({su_n, s0_n, suoen, s0oen} === ob[7:0], "override selects");
            chk(smp === sdi_tb, "input level");
        end
        owner = 1'b0;
        repeat (2) @(negedge mclk_i);
        chk({sck_oen, sdo_oen, s0oen, suoen} === 6'h3f, "released pins");
        {owner, ovr, ob} = {2'h2, 12'hfff};
        miss(28'($urandom) & 28'hffffffc, CMD_READ);
        chk(m_bad === 0, "one select");
        close_out();
    end
endmodule : serial_flash_boot_reader_bench
